// *** hdl/dac_host_pkg.sv ***
// constants and types shared by the converter host controller
package dac_host_pkg;
    // timing
    localparam int REF_NS        = 40;
    localparam int RESET_MIN_NS  = 25;
    localparam int RESET_CYC     = (RESET_MIN_NS + REF_NS - 1) / REF_NS;
    localparam int CONV_PS       = 1000;
    localparam int SYNC_GAP_CONV = 50;
    localparam int GAP_CYC       = (SYNC_GAP_CONV * CONV_PS + REF_NS * 1000 - 1) / (REF_NS * 1000);
    localparam int DCLK_HALF     = 4;
    localparam int SCK_HALF      = 4;
    localparam int FRAME_BITS    = 16;
    // own register byte offsets
    localparam logic [3:0] OFS_CMD    = 4'h0;
    localparam logic [3:0] OFS_CTRL   = 4'h4;
    localparam logic [3:0] OFS_STAT   = 4'h8;
    localparam logic [3:0] OFS_SAMPLE = 4'hC;
    // field positions
    localparam int CMD_RD     = 15;
    localparam int CMD_ADDR   = 8;
    localparam int CTRL_SYNC  = 0;
    localparam int CTRL_DCLK  = 1;
    localparam int CTRL_SDO4  = 2;
    localparam int CTRL_RESET = 3;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_RST   = 1;
    localparam int STAT_LOCK  = 2;
    localparam int STAT_SYNC  = 3;
    localparam int STAT_RDATA = 8;
    // values after reset and response codes
    localparam logic [31:0] CTRL_RST_VAL   = 32'h0000_0000;
    localparam logic [31:0] SAMPLE_RST_VAL = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // device register map reached over the serial port
    localparam logic [4:0] CTRL_REG_ADDR_01 = 5'h01, CTRL_REG_ADDR_02 = 5'h02, CTRL_REG_ADDR_03 = 5'h03;
    localparam logic [4:0] SELFTEST_RESULT_STATUS = 5'h04, CTRL_REG_ADDR_05 = 5'h05, CTRL_REG_ADDR_06 = 5'h06;
    localparam logic [4:0] CTRL_REG_ADDR_0C = 5'h0C, CTRL_REG_ADDR_0D = 5'h0D;
    localparam logic [4:0] SERIAL_OUT_SELECT_REG = 5'h0E, CTRL_REG_ADDR_0F = 5'h0F;

    typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_GAP} ser_state_e;
endpackage : dac_host_pkg

// *** hdl/ser_if.sv ***
// command link between controller core and serial engine
`timescale 1ns/1ps
interface ser_if;
    logic       start;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
    logic       sdo_lvl;
    modport ctrl (output start, rd, addr, wdata, input busy, done, rdata, sdo_lvl);
    modport eng  (input start, rd, addr, wdata, output busy, done, rdata, sdo_lvl);
endinterface : ser_if

// *** hdl/ser_engine.sv ***
// serial register port master: one instruction byte plus one data byte
`timescale 1ns/1ps
module ser_engine #(
    parameter int HALF = dac_host_pkg::SCK_HALF
) (
    input  wire logic clk,
    input  wire logic rst,
    ser_if.eng        bus,
    input  wire logic sdo4,
    input  wire logic sdio_i,
    input  wire logic sdo_i,
    output logic      sclk_ff,
    output logic      sen_n_ff,
    output logic      sdio_o_ff,
    output logic      sdio_oe_ff
);
    // synchronised input must settle between falling and next rising edge
    if (HALF < 3 || HALF > 256) begin : g_chk
        $error("HALF must be 3 to 256");
    end

    dac_host_pkg::ser_state_e state_ff;
    logic [15:0] shreg_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  rdata_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  div_ff;
    logic        rd_ff;
    logic        done_ff;
    logic [1:0]  sdio_s_ff;
    logic [1:0]  sdo_s_ff;
    logic [9:0]  frm_cnt_ff;
    logic        tick;

    always_ff @(posedge clk) begin
        sdio_s_ff <= {sdio_s_ff[0], sdio_i};
        sdo_s_ff  <= {sdo_s_ff[0], sdo_i};
    end

    assign tick        = (div_ff == 8'(HALF - 1));
    assign bus.busy    = (state_ff != dac_host_pkg::SER_IDLE);
    assign bus.done    = done_ff;
    assign bus.rdata   = rdata_ff;
    assign bus.sdo_lvl = sdo_s_ff[1];

    always_ff @(posedge clk) begin
        if (rst || state_ff == dac_host_pkg::SER_IDLE || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        done_ff <= 1'b0;
        if (rst) begin
            state_ff   <= dac_host_pkg::SER_IDLE;
            sclk_ff    <= 1'b0;
            sen_n_ff   <= 1'b1;
            sdio_o_ff  <= 1'b0;
            sdio_oe_ff <= 1'b0;
            shreg_ff   <= 16'h0000;
            rx_ff      <= 8'h00;
            rdata_ff   <= 8'h00;
            bit_ff     <= 4'h0;
            rd_ff      <= 1'b0;
        end else begin
            case (state_ff)
                dac_host_pkg::SER_IDLE: begin
                    if (bus.start) begin
                        shreg_ff   <= {bus.rd, 2'b00, bus.addr, bus.wdata};
                        rd_ff      <= bus.rd;
                        bit_ff     <= 4'hF;
                        sen_n_ff   <= 1'b0;
                        sdio_oe_ff <= 1'b1;
                        sdio_o_ff  <= bus.rd;
                        state_ff   <= dac_host_pkg::SER_SHIFT;
                    end
                end
                dac_host_pkg::SER_SHIFT: begin
                    if (tick && !sclk_ff) begin
                        sclk_ff <= 1'b1;
                        if (rd_ff && bit_ff < 4'h8) begin
                            rx_ff <= {rx_ff[6:0], sdo4 ? sdo_s_ff[1] : sdio_s_ff[1]};
                        end
                    end else if (tick) begin
                        sclk_ff <= 1'b0;
                        if (bit_ff == 4'h0) begin
                            sen_n_ff   <= 1'b1;
                            sdio_oe_ff <= 1'b0;
                            state_ff   <= dac_host_pkg::SER_GAP;
                        end else begin
                            bit_ff     <= bit_ff - 4'h1;
                            shreg_ff   <= {shreg_ff[14:0], 1'b0};
                            sdio_o_ff  <= shreg_ff[14];
                            // release the shared pin for the read data byte
                            sdio_oe_ff <= !rd_ff || bit_ff > 4'h8;
                        end
                    end
                end
                dac_host_pkg::SER_GAP: begin
                    if (tick) begin
                        rdata_ff <= rx_ff;
                        done_ff  <= 1'b1;
                        state_ff <= dac_host_pkg::SER_IDLE;
                    end
                end
                default: state_ff <= dac_host_pkg::SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        frm_cnt_ff <= sen_n_ff ? 10'h000 : frm_cnt_ff + 10'h001;
    end

    frame_length_a: assert property (@(posedge clk) disable iff (rst)
        $rose(sen_n_ff) |-> frm_cnt_ff == 10'(2 * dac_host_pkg::FRAME_BITS * HALF))
        else $error("serial frame length wrong");
    read_release_a: assert property (@(posedge clk) disable iff (rst)
        !sen_n_ff && rd_ff && bit_ff < 4'h8 |-> !sdio_oe_ff)
        else $error("pin driven during read data");
endmodule : ser_engine

// *** hdl/dac_host_ctrl.sv ***
// host controller: AXI4-Lite registers, reset pulse, serial port, sync gate and sample drive
// Operation
// - host supplies a steady data clock; device loop skews it.
// - host programs loop frequency range before starting the loop.
// - host holds hardware reset low at least 25 ns before programming.
// - host sets restart, clears it, then polls lock until it reads 1.
// - data flows only while sync is held at 1.
// - host may send valid samples in the cycle sync rises.
// - multi-converter synchronisation uses the external sync pin only.
// - first step: clear resync disables, toggle common sync.
// - second step: wait 50 converter clocks, then raise and hold sync.
// - host resets, loads self-test values, raises sync, waits, reads flag.
// - host leaves self test by reset and reprogramming.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module dac_host_ctrl #(
    parameter int RESET_HOLD = dac_host_pkg::RESET_CYC,
    parameter int DCLK_DIV   = dac_host_pkg::DCLK_HALF,
    parameter int GAP        = dac_host_pkg::GAP_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic             HW_RESET_N,
    output logic             SCLK,
    output logic             SER_EN_N,
    output logic             SDIO_O,
    output logic             SDIO_OE,
    input  wire logic        SDIO_I,
    input  wire logic        SDO_I,
    output logic             SYNC_GATE,
    output logic             LVDS_DCLK,
    output logic [15:0]      SAMPLE_DATA
);
    if (RESET_HOLD < dac_host_pkg::RESET_CYC || GAP < dac_host_pkg::GAP_CYC || DCLK_DIV < 1
        || RESET_HOLD > 255 || GAP > 255 || DCLK_DIV > 255) begin : g_chk
        $error("parameter out of range");
    end

    ser_if sbus ();

    logic [31:0] cmd_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] sample_ff;
    logic [3:0]  aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    logic        aw_got_ff;
    logic        w_got_ff;
    logic        start_ff;
    logic [7:0]  rst_cnt_ff;
    logic [7:0]  lo_cnt_ff;
    logic [7:0]  gap_cnt_ff;
    logic [7:0]  dclk_cnt_ff;
    logic        nxt_sync;
    logic        wr_fire;
    logic        wr_ok;
    logic [31:0] stat_val;

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a[1:0] == 2'b00);
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    assign wr_fire = aw_got_ff && w_got_ff && !BVALID;
    assign wr_ok   = mapped(aw_addr_ff);

    // write address and data taken in either order, answered once both are in
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            AWREADY   <= 1'b0;
            WREADY    <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            BVALID    <= 1'b0;
            BRESP     <= dac_host_pkg::RESP_OKAY;
        end else begin
            AWREADY <= !aw_got_ff && !(AWVALID && AWREADY) && !BVALID;
            WREADY  <= !w_got_ff && !(WVALID && WREADY) && !BVALID;
            if (AWVALID && AWREADY) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_ff  <= 1'b1;
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
            end
            if (wr_fire) begin
                BVALID    <= 1'b1;
                BRESP     <= wr_ok ? dac_host_pkg::RESP_OKAY : dac_host_pkg::RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // register stores; a command is refused while the engine or the reset pulse is busy
    always_ff @(posedge REF_CLK) begin
        start_ff <= 1'b0;
        if (RST) begin
            cmd_ff    <= 32'h0000_0000;
            ctrl_ff   <= dac_host_pkg::CTRL_RST_VAL;
            sample_ff <= dac_host_pkg::SAMPLE_RST_VAL;
        end else if (wr_fire && wr_ok) begin
            case (aw_addr_ff)
                dac_host_pkg::OFS_CMD: begin
                    if (!sbus.busy && !start_ff && rst_cnt_ff == 8'h00) begin
                        cmd_ff   <= merge(cmd_ff, w_data_ff, w_strb_ff);
                        start_ff <= 1'b1;
                    end
                end
                dac_host_pkg::OFS_CTRL: begin
                    ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff);
                    ctrl_ff[dac_host_pkg::CTRL_RESET] <= 1'b0;
                end
                dac_host_pkg::OFS_SAMPLE: sample_ff <= merge(sample_ff, w_data_ff, w_strb_ff);
                default: ;
            endcase
        end
    end

    assign sbus.start = start_ff;
    assign sbus.rd    = cmd_ff[dac_host_pkg::CMD_RD];
    assign sbus.addr  = cmd_ff[dac_host_pkg::CMD_ADDR +: 5];
    assign sbus.wdata = cmd_ff[7:0];

    // hardware reset pulse; the device needs it before any programming
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rst_cnt_ff <= 8'h00;
            HW_RESET_N <= 1'b1;
        end else if (wr_fire && aw_addr_ff == dac_host_pkg::OFS_CTRL && w_strb_ff[0]
                     && w_data_ff[dac_host_pkg::CTRL_RESET] && rst_cnt_ff == 8'h00
                     && !sbus.busy && !start_ff) begin
            // refused mid-frame, a cut frame would leave the device half written
            rst_cnt_ff <= 8'(RESET_HOLD);
            HW_RESET_N <= 1'b0;
        end else if (rst_cnt_ff > 8'h01) begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
        end else if (rst_cnt_ff == 8'h01 && !sbus.busy) begin
            rst_cnt_ff <= 8'h00;
            HW_RESET_N <= 1'b1;
        end
    end

    // sync pin only follows software after the spacing needed between toggles
    always_comb begin
        nxt_sync = SYNC_GATE;
        if (ctrl_ff[dac_host_pkg::CTRL_SYNC] != SYNC_GATE && gap_cnt_ff >= 8'(GAP)) begin
            nxt_sync = ctrl_ff[dac_host_pkg::CTRL_SYNC];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SYNC_GATE   <= 1'b0;
            gap_cnt_ff  <= 8'h00;
            SAMPLE_DATA <= 16'h0000;
        end else begin
            SYNC_GATE   <= nxt_sync;
            gap_cnt_ff  <= (nxt_sync != SYNC_GATE) ? 8'h00 : (gap_cnt_ff == 8'hFF ? 8'hFF : gap_cnt_ff + 8'h01);
            // samples leave with the same edge that raises sync
            SAMPLE_DATA <= nxt_sync ? sample_ff[15:0] : 16'h0000;
        end
    end

    // free-running data clock while enabled; loop needs it steady
    always_ff @(posedge REF_CLK) begin
        if (RST || !ctrl_ff[dac_host_pkg::CTRL_DCLK]) begin
            dclk_cnt_ff <= 8'h00;
            LVDS_DCLK   <= 1'b0;
        end else if (dclk_cnt_ff == 8'(DCLK_DIV - 1)) begin
            dclk_cnt_ff <= 8'h00;
            LVDS_DCLK   <= !LVDS_DCLK;
        end else begin
            dclk_cnt_ff <= dclk_cnt_ff + 8'h01;
        end
    end

    always_comb begin
        stat_val = 32'h0000_0000;
        stat_val[dac_host_pkg::STAT_BUSY] = sbus.busy || start_ff;
        stat_val[dac_host_pkg::STAT_RST]  = rst_cnt_ff != 8'h00;
        stat_val[dac_host_pkg::STAT_LOCK] = sbus.sdo_lvl;
        stat_val[dac_host_pkg::STAT_SYNC] = SYNC_GATE;
        stat_val[dac_host_pkg::STAT_RDATA +: 8] = sbus.rdata;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= dac_host_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= mapped(ARADDR) ? dac_host_pkg::RESP_OKAY : dac_host_pkg::RESP_SLVERR;
            case (ARADDR)
                dac_host_pkg::OFS_CMD:    RDATA <= cmd_ff;
                dac_host_pkg::OFS_CTRL:   RDATA <= ctrl_ff;
                dac_host_pkg::OFS_STAT:   RDATA <= stat_val;
                dac_host_pkg::OFS_SAMPLE: RDATA <= sample_ff;
                default:                  RDATA <= 32'h0000_0000;
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end else begin
            ARREADY <= !RVALID;
        end
    end

    ser_engine #(.HALF(dac_host_pkg::SCK_HALF)) u_eng (
        .clk        (REF_CLK),
        .rst        (RST),
        .bus        (sbus),
        .sdo4       (ctrl_ff[dac_host_pkg::CTRL_SDO4]),
        .sdio_i     (SDIO_I),
        .sdo_i      (SDO_I),
        .sclk_ff    (SCLK),
        .sen_n_ff   (SER_EN_N),
        .sdio_o_ff  (SDIO_O),
        .sdio_oe_ff (SDIO_OE)
    );

    always_ff @(posedge REF_CLK) begin
        lo_cnt_ff <= HW_RESET_N ? 8'h00 : lo_cnt_ff + 8'h01;
    end

    reset_width_a: assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(HW_RESET_N) |-> lo_cnt_ff >= 8'(RESET_HOLD))
        else $error("reset pulse too short");
    no_cmd_reset_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !HW_RESET_N |-> SER_EN_N)
        else $error("serial frame during reset");
    sync_gap_a: assert property (@(posedge REF_CLK) disable iff (RST)
        $changed(SYNC_GATE) |-> $past(gap_cnt_ff) >= 8'(GAP))
        else $error("sync toggled too soon");
    sample_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !SYNC_GATE |-> SAMPLE_DATA == 16'h0000)
        else $error("samples sent with sync low");
    sample_align_a: assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(SYNC_GATE) |-> SAMPLE_DATA == $past(sample_ff[15:0]))
        else $error("first sample not with sync rise");
    dclk_period_a: assert property (@(posedge REF_CLK) disable iff (RST)
        $changed(LVDS_DCLK) && ctrl_ff[dac_host_pkg::CTRL_DCLK] |-> $past(dclk_cnt_ff) == 8'(DCLK_DIV - 1))
        else $error("data clock half period wrong");
    cmd_refused_a: assert property (@(posedge REF_CLK) disable iff (RST)
        sbus.busy |-> !sbus.start)
        else $error("serial start while busy");
    bresp_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
endmodule : dac_host_ctrl

// *** verification/dac_dev_model.sv ***
// behavioural converter device: serial register port, loop lock flag, reset
`timescale 1ns/1ps
module dac_dev_model #(
    parameter logic [4:0] LOCK_ADDR    = 5'h00,
    parameter logic [4:0] RESTART_ADDR = 5'h08
) (
    input  wire logic hw_reset_n,
    input  wire logic sclk,
    input  wire logic sen_n,
    input  wire logic sdio,
    input  wire logic dclk,
    input  wire logic sync,
    output logic      sdio_o,
    output logic      sdio_oe,
    output logic      serial_data_out_pin
);
    logic [7:0]  regs [32];
    logic [15:0] sh;
    logic [7:0]  ins;
    logic [7:0]  rdv;
    logic        lock;
    int          n;
    int          edges;
    logic        sync_q;
    logic        sync_d;
    int          sync_events = 0;
    // sync stored on both data clock edges, rising edge found after the store
    always @(dclk) begin
        sync_q <= sync;
        sync_d <= sync_q;
        if (sync_q && !sync_d) sync_events++;
    end
    initial sdio_oe = 1'b0;
    always @(negedge hw_reset_n or negedge sen_n) begin
        n = 0;
        ins = 8'h00;
        if (!hw_reset_n) for (int i = 0; i < 32; i++) regs[i] = 8'h00;
    end
    initial for (int i = 0; i < 32; i++) regs[i] = 8'h00;
    // data taken on the rising serial clock
    always @(posedge sclk) if (!sen_n) begin
        sh = {sh[14:0], sdio};
        n++;
        if (n == 8) ins = sh[7:0];
    end
    assign rdv = (ins[4:0] == LOCK_ADDR) ? {7'h00, lock} : regs[ins[4:0]];
    // read data launched on the falling edge, released at frame end
    always @(negedge sclk) if (!sen_n && ins[7] && n >= 8 && n < 16) begin
        sdio_oe = 1'b1;
        sdio_o = rdv[15-n];
    end
    always @(posedge sen_n) begin
        if (hw_reset_n && n == 16 && !sh[15]) regs[sh[12:8]] = sh[7:0];
        sdio_oe = 1'b0;
    end
    // lock needs a running data clock with restart cleared
    always @(posedge dclk or negedge hw_reset_n) begin
        if (!hw_reset_n || regs[RESTART_ADDR][0]) edges <= 0;
        else if (edges < 4) edges <= edges + 1;
    end
    assign lock = (edges >= 4);
    assign serial_data_out_pin = lock;
endmodule : dac_dev_model

// *** verification/test_dac_host_ctrl.sv ***
// self-checking bench for the converter host controller
`timescale 1ns/1ps
module test_dac_host_ctrl;
    logic        REF_CLK = 1'b0, RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic        ARVALID = 1'b0, RREADY = 1'b0;
    logic [3:0]  AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
    logic [31:0] WDATA = 32'h0, RDATA, rd;
    logic [1:0]  BRESP, RRESP, rsp;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, HW_RESET_N, SCLK, SER_EN_N;
    logic        SDIO_O, SDIO_OE, SERIAL_DATA_OUT_PIN, SYNC_GATE, LVDS_DCLK, dev_o, dev_oe, sdio_w;
    logic [15:0] SAMPLE_DATA;
    logic [4:0]  ta [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0C, 5'h0D, 5'h0E, 5'h0F};
    logic [7:0]  tv [10] = '{8'h18, 8'hEA, 8'hB0, 8'h00, 8'h06, 8'h0F, 8'h0A, 8'h55, 8'h0A, 8'hAA};
    int          fail_count = 0, n_tests = 0, lowc = 0, k;
    time         t0;
    localparam int GAP_B = 6;
    always #20 REF_CLK = ~REF_CLK;
    // shared pin has a pull-down at the device
    assign sdio_w = SDIO_OE ? SDIO_O : (dev_oe ? dev_o : 1'b0);
    always @(posedge REF_CLK) if (HW_RESET_N !== 1'b1) lowc++;
    dac_host_ctrl #(.RESET_HOLD(1), .DCLK_DIV(4), .GAP(GAP_B)) i_dac_host_ctrl (.REF_CLK(REF_CLK), .RST(RST),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .HW_RESET_N(HW_RESET_N), .SCLK(SCLK), .SER_EN_N(SER_EN_N),
        .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .SDIO_I(sdio_w), .SDO_I(SERIAL_DATA_OUT_PIN), .SYNC_GATE(SYNC_GATE),
        .LVDS_DCLK(LVDS_DCLK), .SAMPLE_DATA(SAMPLE_DATA));
    dac_dev_model i_dac_dev_model (.hw_reset_n(HW_RESET_N), .sclk(SCLK), .sen_n(SER_EN_N), .sdio(sdio_w),
        .dclk(LVDS_DCLK), .sync(SYNC_GATE), .sdio_o(dev_o), .sdio_oe(dev_oe), .serial_data_out_pin(SERIAL_DATA_OUT_PIN));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int i);
        if (i >= 3000) begin
            fail_count++;
            $display("[ERR] %0t wait ran out", $time);
            stop_test();
        end
    endtask : tmo
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge REF_CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (i = 0; i < 3000 && BVALID !== 1'b1; i++) begin
            @(posedge REF_CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
        end
        tmo(i);
        rsp = BRESP;
        BREADY <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        int i;
        @(posedge REF_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (i = 0; i < 3000 && RVALID !== 1'b1; i++) begin
            @(posedge REF_CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
        end
        tmo(i);
        rd = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
    endtask : axi_rd
    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000; i++) begin
            axi_rd(dac_host_pkg::OFS_STAT);
            if (rd[dac_host_pkg::STAT_BUSY] === 1'b0) break;
        end
        tmo(i);
    endtask : wait_idle
    // one device frame, then poll busy until the engine is idle
    task automatic dev_cmd(input logic rdf, input logic [4:0] a, input logic [7:0] d);
        axi_wr(dac_host_pkg::OFS_CMD, {16'h0000, rdf, 2'b00, a, d});
        wait_idle();
    endtask : dev_cmd
    initial begin
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        axi_rd(dac_host_pkg::OFS_CTRL);
        chk(rd, dac_host_pkg::CTRL_RST_VAL);
        axi_rd(dac_host_pkg::OFS_SAMPLE);
        chk(rd, dac_host_pkg::SAMPLE_RST_VAL);
        chk(32'(SAMPLE_DATA), 32'h0);
        axi_rd(4'h2);
        chk(32'(rsp), 32'(dac_host_pkg::RESP_SLVERR));
        axi_wr(4'h7, 32'h1);
        chk(32'(rsp), 32'(dac_host_pkg::RESP_SLVERR));
        $display("test reset and map done");
        for (int i = 0; i < 10; i++) dev_cmd(1'b0, ta[i], tv[i]);
        for (int i = 0; i < 10; i++) chk(32'(i_dac_dev_model.regs[ta[i]]), 32'(tv[i]));
        // a second frame offered while busy is answered but dropped
        axi_wr(dac_host_pkg::OFS_CMD, 32'h0000_0A5A);
        axi_wr(dac_host_pkg::OFS_CMD, 32'h0000_0B3C);
        chk(32'(rsp), 32'(dac_host_pkg::RESP_OKAY));
        // the first frame must end before the next command is taken
        wait_idle();
        dev_cmd(1'b1, 5'h05, 8'h00);
        chk(32'(rd[15:8]), 32'h06);
        chk(32'(i_dac_dev_model.regs[5'h0B]), 32'h0);
        chk(32'(i_dac_dev_model.regs[5'h0A]), 32'h5A);
        lowc = 0;
        axi_wr(dac_host_pkg::OFS_CTRL, 32'h8);
        dev_cmd(1'b1, 5'h05, 8'h00);
        chk(32'(lowc), 32'd1);
        chk(32'(rd[15:8]), 32'h00);
        axi_rd(dac_host_pkg::OFS_CTRL);
        chk(rd, 32'h0);
        $display("test register load and reset done");
        dev_cmd(1'b0, 5'h08, 8'h01);
        axi_wr(dac_host_pkg::OFS_CTRL, 32'h2);
        for (k = 0; k < 3000 && LVDS_DCLK !== 1'b1; k++) @(posedge REF_CLK);
        tmo(k);
        for (k = 0; k < 3000 && LVDS_DCLK !== 1'b0; k++) @(posedge REF_CLK);
        for (k = 0; k < 3000 && LVDS_DCLK !== 1'b1; k++) @(posedge REF_CLK);
        chk(32'(k), 32'd4);
        repeat (20) @(posedge REF_CLK);
        axi_rd(dac_host_pkg::OFS_STAT);
        chk(32'(rd[dac_host_pkg::STAT_LOCK]), 32'h0);
        dev_cmd(1'b0, 5'h08, 8'h00);
        for (k = 0; k < 3000; k++) begin
            axi_rd(dac_host_pkg::OFS_STAT);
            if (rd[dac_host_pkg::STAT_LOCK] === 1'b1) break;
        end
        tmo(k);
        dev_cmd(1'b1, 5'h00, 8'h00);
        chk(32'(rd[15:8]), 32'h01);
        $display("test loop lock done");
        axi_wr(dac_host_pkg::OFS_SAMPLE, 32'h0000_A5C3);
        axi_wr(dac_host_pkg::OFS_CTRL, 32'h3);
        for (k = 0; k < 3000 && SYNC_GATE !== 1'b1; k++) @(posedge REF_CLK);
        tmo(k);
        t0 = $time;
        chk(32'(SAMPLE_DATA), 32'hA5C3);
        // lowered at once, so the fall has to wait out the spacing
        axi_wr(dac_host_pkg::OFS_CTRL, 32'h2);
        for (k = 0; k < 3000 && SYNC_GATE !== 1'b0; k++) @(posedge REF_CLK);
        tmo(k);
        chk(32'(($time - t0) / dac_host_pkg::REF_NS >= GAP_B), 32'h1);
        #1;
        chk(32'(SAMPLE_DATA), 32'h0);
        axi_rd(dac_host_pkg::OFS_STAT);
        chk(32'(rd[dac_host_pkg::STAT_SYNC]), 32'h0);
        chk(32'(i_dac_dev_model.sync_events), 32'h1);
        $display("test sync gate done");
        stop_test();
    end
endmodule : test_dac_host_ctrl
